// ==== rail_code_pkg.sv ====
package rail_code_pkg;

  // ****************************************
  // Rail-select addresses
  // ****************************************
  localparam int RAIL_W = 4;
  localparam logic [3:0] RAIL_PROC = 4'h0;
  localparam logic [3:0] RAIL_SYS_AGENT = 4'h1;
  localparam logic [3:0] RAIL_MEM_A = 4'h2;
  localparam logic [3:0] RAIL_MEM_A_SPARE = 4'h3;
  localparam logic [3:0] RAIL_MEM_B = 4'h4;
  localparam logic [3:0] RAIL_MEM_B_SPARE = 4'h5;

  // ****************************************
  // Voltage codes
  // ****************************************
  localparam logic [7:0] CODE_OFF = 8'h00;
  localparam logic [7:0] CODE_UNUSED_LO = 8'h01;
  localparam logic [7:0] CODE_UNUSED_HI = 8'h32;
  localparam logic [7:0] CODE_MIN = 8'h33;
  localparam logic [7:0] CODE_MAX = 8'hff;
  localparam int CODE_MIN_UV = 500000;
  localparam int CODE_STEP_UV = 5000;
  localparam logic [7:0] CODE_MEM_1V35 = 8'hdd;
  localparam logic [7:0] CODE_MEM_1V50 = 8'hfb;
  localparam logic [7:0] MAX_OUT_REG = 8'h30;
  localparam logic [7:0] RESET_LIMIT = 8'hff;

  // ****************************************
  // Commands and carriers
  // ****************************************
  typedef enum logic [1:0] {
    CMD_SET_VOLTAGE,
    CMD_SET_LIMIT,
    CMD_POWER_STATE
  } cmd_e;

  typedef struct packed {
    logic [3:0] rail;
    cmd_e cmd;
    logic [7:0] payload;
  } packet_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND
  } state_e;

endpackage

// ==== serial_voltage_rail_codes.sv ====
// Behaviour
// - Every packet carries a four-bit rail-select address.
// - Four rails: processor rail at 00, system agent at 01.
// - Code 00h means off; codes 01h-32h are never sent as voltage or limit codes.
// - Codes 33h..FFh map to 0.5 V plus 5 mV per step.
// - Memory rails get only off or fixed 1.35 V or 1.5 V.
// - Set-voltage carries the code as one payload byte, one rail.
// - Device programs maximum-output register with the code of a set-limit request.
`timescale 1ns/10ps
module serial_voltage_rail_codes (
  input wire logic mclk, // 100 MHz clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic reqValid, // Request to send
  input wire logic [1:0] reqRail, // 0 proc,1 sys agent,2 mem A,3 mem B
  input wire rail_code_pkg::cmd_e reqCmd, // Command kind
  input wire logic [7:0] reqCode, // Voltage code or power state byte
  input wire logic memHighVolt, // Memory rails at 1.5 V when high
  output logic reqReady, // Request accepted this cycle
  output logic reqBlocked, // Request refused, one-cycle pulse
  output logic pktValid, // Packet presented to bus engine
  input wire logic pktReady, // Bus engine takes packet
  output rail_code_pkg::packet_s pkt, // Packet fields
  output logic [7:0] limitCode // Programmed maximum code
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rail_code_pkg::state_e st;
    rail_code_pkg::packet_s pkt;
    logic blocked;
    logic [7:0] limit;
  } regs_s;

  regs_s r;
  regs_s next_r;
  logic [3:0] railAddr;
  logic [7:0] code;
  logic codeOk;

  // ****************************************
  // Rail address and code selection
  // ****************************************
  always_comb
  begin
    unique case (reqRail)
      2'd0: railAddr = rail_code_pkg::RAIL_PROC;
      2'd1: railAddr = rail_code_pkg::RAIL_SYS_AGENT;
      2'd2: railAddr = rail_code_pkg::RAIL_MEM_A;
      2'd3: railAddr = rail_code_pkg::RAIL_MEM_B;
    endcase
  end

  always_comb
  begin
    code = reqCode;
    // Memory rails never sweep: fixed target or off
    if (reqCmd == rail_code_pkg::CMD_SET_VOLTAGE && reqRail[1] &&
        reqCode != rail_code_pkg::CODE_OFF)
    begin
      code = memHighVolt ? rail_code_pkg::CODE_MEM_1V50
                         : rail_code_pkg::CODE_MEM_1V35;
    end
  end

  // Power state passes any byte; others off or 33h..FFh only; set-voltage also bounded by limit
  assign codeOk = (reqCmd == rail_code_pkg::CMD_POWER_STATE) ||
    ((code == rail_code_pkg::CODE_OFF ||
      code >= rail_code_pkg::CODE_MIN) &&
     (reqCmd != rail_code_pkg::CMD_SET_VOLTAGE || code <= r.limit));

  assign reqReady = (r.st == rail_code_pkg::ST_IDLE) && codeOk;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    next_r = r;
    next_r.blocked = 1'b0;
    unique case (r.st)
      rail_code_pkg::ST_IDLE:
      begin
        if (reqValid && codeOk)
        begin
          next_r.pkt.rail = railAddr;
          next_r.pkt.cmd = reqCmd;
          next_r.pkt.payload = code;
          if (reqCmd == rail_code_pkg::CMD_SET_LIMIT)
            next_r.limit = code;
          next_r.st = rail_code_pkg::ST_SEND;
        end
        else if (reqValid)
          next_r.blocked = 1'b1;
      end
      rail_code_pkg::ST_SEND:
      begin
        if (pktReady)
          next_r.st = rail_code_pkg::ST_IDLE;
      end
      default: next_r.st = rail_code_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      r.st <= rail_code_pkg::ST_IDLE;
      r.pkt <= '0;
      r.blocked <= 1'b0;
      r.limit <= rail_code_pkg::RESET_LIMIT;
    end
    else
      r <= next_r;
  end

  assign pktValid = (r.st == rail_code_pkg::ST_SEND);
  assign pkt = r.pkt;
  assign reqBlocked = r.blocked;
  assign limitCode = r.limit;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_code_range: assert property (pktValid &&
    pkt.cmd != rail_code_pkg::CMD_POWER_STATE |->
    (pkt.payload == 8'h00 || pkt.payload >= 8'h33))
    else $error("Unused voltage code sent");
  chk_rail_addr: assert property (pktValid |->
    pkt.rail inside {4'h0, 4'h1, 4'h2, 4'h4})
    else $error("Illegal rail address");
  chk_mem_fixed: assert property (pktValid &&
    pkt.cmd == rail_code_pkg::CMD_SET_VOLTAGE && pkt.rail[3:1] != 3'h0 |->
    pkt.payload inside {8'h00, 8'hdd, 8'hfb})
    else $error("Memory rail swept");
  chk_limit_held: assert property (pktValid &&
    pkt.cmd == rail_code_pkg::CMD_SET_VOLTAGE |-> pkt.payload <= limitCode)
    else $error("Code above limit");
  chk_block_pulse: assert property (reqValid && !codeOk &&
    r.st == rail_code_pkg::ST_IDLE |=> reqBlocked && !pktValid)
    else $error("Bad code not blocked");
  chk_accept_send: assert property (reqValid && reqReady |=>
    pktValid && pkt.payload == $past(code) && pkt.rail == $past(railAddr))
    else $error("Accepted request not sent");
  chk_hold_stall: assert property (pktValid && !pktReady |=>
    pktValid && $stable(pkt))
    else $error("Packet changed while stalled");
  chk_proc_addr: assert property (reqValid && reqReady &&
    reqRail == 2'd0 |=> pkt.rail == 4'h0)
    else $error("Processor rail address wrong");

  // ****************************************
  // Rail address checks
  // ****************************************
  chk_agent_addr: assert property (reqValid && reqReady &&
    reqRail == 2'd1 |=> pkt.rail == rail_code_pkg::RAIL_SYS_AGENT)
    else $error("System agent rail address wrong");
  chk_mem_a_addr: assert property (reqValid && reqReady &&
    reqRail == 2'd2 |=> pkt.rail == rail_code_pkg::RAIL_MEM_A)
    else $error("Memory pair A rail address wrong");
  chk_mem_b_addr: assert property (reqValid && reqReady &&
    reqRail == 2'd3 |=> pkt.rail == rail_code_pkg::RAIL_MEM_B)
    else $error("Memory pair B rail address wrong");

  // ****************************************
  // Voltage code checks
  // ****************************************
  chk_mem_volts: assert property (pktValid &&
    pkt.cmd == rail_code_pkg::CMD_SET_VOLTAGE && pkt.rail[3:1] != 3'h0 &&
    pkt.payload != 8'h00 |->
    (((int'(pkt.payload) - 51) * 5 + 500) inside {1350, 1500}))
    else $error("Memory rail target not 1.35 V or 1.5 V");
  chk_mem_select: assert property (reqValid && reqReady &&
    reqCmd == rail_code_pkg::CMD_SET_VOLTAGE && reqRail[1] &&
    reqCode != 8'h00 |=>
    pkt.payload == ($past(memHighVolt) ? 8'hfb : 8'hdd))
    else $error("Memory rail target not selected");
  chk_off_kept: assert property (reqValid && reqReady &&
    reqCmd != rail_code_pkg::CMD_POWER_STATE && reqCode == 8'h00 |=>
    pkt.payload == 8'h00)
    else $error("Off request altered");
  chk_unused_refused: assert property (reqValid &&
    reqCmd == rail_code_pkg::CMD_SET_LIMIT &&
    reqCode inside {[8'h01:8'h32]} |-> !reqReady)
    else $error("Unused limit code accepted");
  chk_code_pass: assert property (reqValid && reqReady &&
    !(reqRail[1] && reqCmd == rail_code_pkg::CMD_SET_VOLTAGE) |=>
    pkt.payload == $past(reqCode) && pkt.cmd == $past(reqCmd))
    else $error("Payload byte altered");

  // ****************************************
  // Limit checks
  // ****************************************
  chk_limit_write: assert property (reqValid && reqReady &&
    reqCmd == rail_code_pkg::CMD_SET_LIMIT |=>
    limitCode == $past(reqCode))
    else $error("Limit not programmed");
  chk_limit_stable: assert property (!(reqValid && reqReady &&
    reqCmd == rail_code_pkg::CMD_SET_LIMIT) |=> $stable(limitCode))
    else $error("Limit changed without request");

  // ****************************************
  // Handshake checks
  // ****************************************
  chk_busy_ready: assert property (pktValid |-> !reqReady)
    else $error("Ready while packet pending");
  chk_pkt_release: assert property (pktValid && pktReady |=>
    !pktValid)
    else $error("Packet not released");
  chk_block_cause: assert property (reqBlocked |->
    $past(reqValid && !reqReady))
    else $error("Block pulse without refused request");

  cov_send_proc: cover property (pktValid && pktReady && pkt.rail == 4'h0);
  cov_blocked: cover property (reqBlocked);
  cov_mem_b: cover property (pktValid && pkt.rail == 4'h4);
  cov_limit: cover property (pktValid &&
    pkt.cmd == rail_code_pkg::CMD_SET_LIMIT);
  cov_power: cover property (pktValid &&
    pkt.cmd == rail_code_pkg::CMD_POWER_STATE);

endmodule

// ==== reg_model.sv ====
`timescale 1ns/10ps
module reg_model (
  input wire logic mclk, // Clock
  input wire logic stall, // Hold off taking packets
  input wire logic pktValid, // Packet offered
  output logic pktReady, // Packet taken
  input wire rail_code_pkg::packet_s pkt, // Packet fields
  output logic [1:0] ack // 1 ok, 2 unsupported, 3 rejected
);
  logic [7:0] maxCode = 8'hff;
  assign pktReady = pktValid && !stall;
  always @(posedge mclk)
  begin
    if (pktReady)
    begin
      if (pkt.cmd == rail_code_pkg::CMD_SET_LIMIT)
        maxCode <= pkt.payload;
      // One address per rail; offsets 3 and 5 stay silent
      if (pkt.rail inside {4'h3, 4'h5, [4'h6:4'hf]})
        ack <= 2'h0;
      else if (pkt.cmd == rail_code_pkg::CMD_POWER_STATE)
        ack <= (pkt.payload > 8'h02) ? 2'h3 : 2'h1;
      else if (pkt.cmd == rail_code_pkg::CMD_SET_VOLTAGE)
        ack <= (pkt.payload > maxCode) ? 2'h2 : 2'h1;
      else
        ack <= 2'h1;
    end
  end
endmodule

// ==== test_serial_voltage_rail_codes.sv ====
`timescale 1ns/10ps
module test_serial_voltage_rail_codes;
  logic mclk = 0, resetn = 0, reqValid = 0, memHighVolt = 0, stall = 0;
  logic [1:0] reqRail = 0;
  rail_code_pkg::cmd_e reqCmd = rail_code_pkg::CMD_SET_VOLTAGE;
  logic [7:0] reqCode = 0, limitCode, lim = 8'hff;
  logic reqReady, reqBlocked, pktValid, pktReady;
  logic [1:0] ack;
  rail_code_pkg::packet_s pkt;
  logic [31:0] seed = 32'h4720fdbb;
  logic [12:0] corner [13] = '{13'h0000, 13'h0401, 13'h0032, 13'h0033,
    13'h04ff, 13'h0840, 13'h1c40, 13'h0180, 13'h0081, 13'h0080,
    13'h0910, 13'h0203, 13'h01ff};
  int err_total = 0, compares = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) stall <= seed[7] && !stall;
  serial_voltage_rail_codes i_serial_voltage_rail_codes (.mclk(mclk),
    .resetn(resetn), .reqValid(reqValid), .reqRail(reqRail),
    .reqCmd(reqCmd), .reqCode(reqCode), .memHighVolt(memHighVolt),
    .reqReady(reqReady), .reqBlocked(reqBlocked), .pktValid(pktValid),
    .pktReady(pktReady), .pkt(pkt), .limitCode(limitCode));
  reg_model i_reg_model (.mclk(mclk), .stall(stall), .pktValid(pktValid),
    .pktReady(pktReady), .pkt(pkt), .ack(ack));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(string n, logic [23:0] e, logic [23:0] s);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic waitIdle();
    int k;
    k = 0;
    @(negedge mclk);
    while (pktValid !== 1'b0 && k < 20)
    begin
      @(negedge mclk);
      k++;
    end
    if (pktValid !== 1'b0)
    begin
      err_total++;
      conclude();
    end
  endtask
  task automatic send(logic h, logic [1:0] r, logic [1:0] c, logic [7:0] v);
    logic [7:0] pay;
    logic bad;
    waitIdle();
    pay = (r[1] && c == 0 && v != 0) ? (h ? 8'hfb : 8'hdd) : v;
    bad = c != 2 && pay inside {[8'h01:8'h32]};
    bad |= c == 0 && pay > lim;
    @(posedge mclk);
    reqValid <= 1;
    reqRail <= r;
    reqCmd <= rail_code_pkg::cmd_e'(c);
    reqCode <= v;
    memHighVolt <= h;
    @(negedge mclk);
    check("ready", !bad, reqReady);
    @(posedge mclk);
    reqValid <= 0;
    @(negedge mclk);
    check("flags", bad ? 2'b01 : 2'b10, {pktValid, reqBlocked});
    if (!bad)
      check("pkt", {r == 3 ? 4'h4 : {2'b0, r}, c, pay}, pkt);
    if (!bad && c == 1)
      lim = v;
    check("limit", lim, limitCode);
    if (!bad)
    begin
      waitIdle();
      check("ack", c == 2 && v > 2 ? 2'h3 : 2'h1, ack);
    end
  endtask
  initial
  begin
    logic [31:0] x;
    repeat (20) @(posedge mclk);
    resetn <= 1;
    @(negedge mclk);
    check("reset", 24'h0000ff,
      {pktValid, reqBlocked, pkt, limitCode});
    foreach (corner[i])
      send(corner[i][12], corner[i][11:10], corner[i][9:8], corner[i][7:0]);
    @(posedge mclk);
    resetn <= 0;
    repeat (2) @(posedge mclk);
    resetn <= 1;
    lim = 8'hff;
    @(negedge mclk);
    check("rerun", 24'h0000ff,
      {pktValid, reqBlocked, pkt, limitCode});
    send(1'b0, 2'd0, 2'd1, 8'hff);
    repeat (60)
    begin
      x = rnd();
      send(x[12], x[11:10], x[9] ? 2'd2 : x[9:8], x[9] ? x[1:0] : x[7:0]);
    end
    conclude();
  end
endmodule
